// [shared/sssb_pkg.sv]
package sssb_pkg;

  // register width and reset value
  localparam int unsigned SSSB_DW = 8;
  localparam logic [7:0] SSSB_RESET = 8'h00;

  // word indices; byte address is four times the index
  localparam int unsigned SSSB_IDX_W = 10;
  localparam logic [9:0] SSSB_IDX_STEP_LOW = 10'h1AC;
  localparam logic [9:0] SSSB_IDX_STEP_HIGH = 10'h1AD;
  localparam logic [9:0] SSSB_IDX_MON = 10'h1B0;
  localparam logic [9:0] SSSB_IDX_CTRL = 10'h1B4;
  localparam logic [9:0] SSSB_IDX_IRQ_STAT = 10'h1B5;
  localparam logic [9:0] SSSB_IDX_IRQ_MASK = 10'h1B6;

  // implemented bits of each register
  localparam logic [7:0] SSSB_STEP_LOW_MASK = 8'hF3;
  localparam logic [7:0] SSSB_STEP_HIGH_MASK = 8'h3F;
  localparam logic [7:0] SSSB_MON_MASK = 8'h34;
  localparam logic [7:0] SSSB_MON_ALT_MASK = 8'hF4;
  localparam logic [7:0] SSSB_CTRL_MASK = 8'h01;
  localparam logic [7:0] SSSB_IRQ_MASK_BITS = 8'h07;

  // field positions
  localparam int unsigned SSSB_S1_D_BIT = 7;
  localparam int unsigned SSSB_S1_A_BIT = 4;
  localparam int unsigned SSSB_S0_B_BIT = 1;
  localparam int unsigned SSSB_S0_A_BIT = 0;
  localparam int unsigned SSSB_S3_B_BIT = 5;
  localparam int unsigned SSSB_S3_A_BIT = 4;
  localparam int unsigned SSSB_S2_D_BIT = 3;
  localparam int unsigned SSSB_S2_C_BIT = 2;
  localparam int unsigned SSSB_S2_A_BIT = 0;
  localparam int unsigned SSSB_MON_ALIGN_D_BIT = 7;
  localparam int unsigned SSSB_MON_ALIGN_C_BIT = 6;
  localparam int unsigned SSSB_MON_ALIGN_B_BIT = 5;
  localparam int unsigned SSSB_MON_ALIGN_A_BIT = 4;
  localparam int unsigned SSSB_MON_LOL_BIT = 2;
  localparam int unsigned SSSB_CTRL_ALT_BIT = 0;
  localparam int unsigned SSSB_IRQ_STEP_LOW_BIT = 0;
  localparam int unsigned SSSB_IRQ_STEP_HIGH_BIT = 1;
  localparam int unsigned SSSB_IRQ_MON_BIT = 2;

endpackage : sssb_pkg

// [src/sssb_sticky_reg.sv]
`timescale 1ns/1ps
module sssb_sticky_reg #(
  parameter int unsigned W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  input wire logic [W-1:0] keep_i,
  output logic [W-1:0] flags_o,
  output logic event_o
);

  // set wins over clear; unimplemented bits stay zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_o <= '0;
    end else if (ce_i) begin
      flags_o <= ((flags_o & ~clr_i) | set_i) & keep_i;
    end
  end

  assign event_o = ce_i & (|(set_i & keep_i));

endmodule : sssb_sticky_reg

// [src/sssb_wb_port.sv]
`timescale 1ns/1ps
module sssb_wb_port #(
  parameter int unsigned ADR_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  output logic wb_ack_o,
  output logic [ADR_W-3:0] idx_o,
  output logic cap_o,
  output logic done_o
);

  logic req;

  assign req = wb_cyc_i & wb_stb_i;
  assign idx_o = wb_adr_i[ADR_W-1:2];
  // load read data while waiting, commit on the edge that sees ack
  assign cap_o = ce_i & req & ~wb_ack_o;
  assign done_o = ce_i & req & wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

endmodule : sssb_wb_port

// [src/sssb_bank.sv]
// What this block does
// [R1] Phase-step completion of synth one dividers D, C, B, A latches bits 7..4 of the low step register.
// [R2] Phase-step completion of synth zero dividers B and A latches bits 1 and 0, with bits 3:2 reading zero.
// [R3] Phase-step completion of synth three dividers B and A latches bits 5 and 4 of the high step register.
// [R4] Phase-step completion of synth two dividers D, C, B, A latches bits 3..0 of the high step register.
// [R5] Alignment completion of synth zero dividers A and B sets bits 4 and 5 of the monitor register.
// [R6] Synth_unlocked_flag in synth zero sets bit 2 of the monitor register until acknowledged.
// [R7] In the alternate layout bits 7 and 6 latch alignment of dividers D and C, and bits 3, 1:0 read zero.
// [R8] A flag clears only on a write of one to it, and an event in the same cycle keeps it set; monitor bits 7:6 also clear on leaving alternate layout.
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
module sssb_bank
  import sssb_pkg::*;
#(
  parameter int unsigned ADR_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic s1_divider_d_step_done_i,
  input wire logic s1_divider_c_step_done_i,
  input wire logic s1_divider_b_step_done_i,
  input wire logic s1_divider_a_step_done_i,
  input wire logic s0_divider_b_step_done_i,
  input wire logic s0_divider_a_step_done_i,
  input wire logic s3_divider_b_step_done_i,
  input wire logic s3_divider_a_step_done_i,
  input wire logic s2_divider_d_step_done_i,
  input wire logic s2_divider_c_step_done_i,
  input wire logic s2_divider_b_step_done_i,
  input wire logic s2_divider_a_step_done_i,
  input wire logic s0_align_d_done_i,
  input wire logic s0_align_c_done_i,
  input wire logic s0_align_b_done_i,
  input wire logic s0_align_a_done_i,
  input wire logic synth_unlocked_flag_i,
  output logic irq_o
);

  localparam int unsigned IW = ADR_W - 2;

  generate
    if (ADR_W < SSSB_IDX_W + 2) begin : g_bad_adr
      $error("address width too small for the register map");
    end
  endgenerate

  logic [IW-1:0] idx;
  logic cap;
  logic done;
  logic wr_done;
  logic rd_done;
  logic hit_low;
  logic hit_high;
  logic hit_mon;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_mask;
  logic [7:0] wr_byte;
  logic [7:0] step_low;
  logic [7:0] step_high;
  logic [7:0] mon;
  logic [7:0] ctrl;
  logic [7:0] irq_mask;
  logic [7:0] irq_stat;
  logic [7:0] set_low;
  logic [7:0] set_high;
  logic [7:0] set_mon;
  logic [7:0] clr_low;
  logic [7:0] clr_high;
  logic [7:0] clr_mon;
  logic [7:0] clr_stat;
  logic [7:0] set_stat;
  logic [7:0] mon_keep;
  logic [7:0] next_rd;
  logic ctrl_alt;
  logic ev_low;
  logic ev_high;
  logic ev_mon;

  sssb_wb_port #(
    .ADR_W(ADR_W)
  ) u_port (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_adr_i(wb_adr_i),
    .wb_ack_o(wb_ack_o),
    .idx_o(idx),
    .cap_o(cap),
    .done_o(done)
  );

  // address decode
  assign hit_low = (idx == IW'(SSSB_IDX_STEP_LOW));
  assign hit_high = (idx == IW'(SSSB_IDX_STEP_HIGH));
  assign hit_mon = (idx == IW'(SSSB_IDX_MON));
  assign hit_ctrl = (idx == IW'(SSSB_IDX_CTRL));
  assign hit_stat = (idx == IW'(SSSB_IDX_IRQ_STAT));
  assign hit_mask = (idx == IW'(SSSB_IDX_IRQ_MASK));
  assign wr_done = done & wb_we_i & wb_sel_i[0];
  assign rd_done = done & ~wb_we_i;
  assign wr_byte = wb_dat_i[7:0];
  assign ctrl_alt = ctrl[SSSB_CTRL_ALT_BIT];

  // event vectors in register layout
  assign set_low = {s1_divider_d_step_done_i, s1_divider_c_step_done_i,
                    s1_divider_b_step_done_i, s1_divider_a_step_done_i, 2'b00,
                    s0_divider_b_step_done_i, s0_divider_a_step_done_i}; // [R1] [R2]
  assign set_high = {2'b00, s3_divider_b_step_done_i, s3_divider_a_step_done_i,
                     s2_divider_d_step_done_i, s2_divider_c_step_done_i,
                     s2_divider_b_step_done_i, s2_divider_a_step_done_i}; // [R3] [R4]
  assign set_mon = {s0_align_d_done_i, s0_align_c_done_i, s0_align_b_done_i, s0_align_a_done_i,
                    1'b0, synth_unlocked_flag_i, 2'b00}; // [R5] [R6] [R7]
  assign mon_keep = ctrl_alt ? SSSB_MON_ALT_MASK : SSSB_MON_MASK; // [R7]

  // write one to acknowledge
  assign clr_low = (wr_done & hit_low) ? wr_byte : SSSB_RESET; // [R8]
  assign clr_high = (wr_done & hit_high) ? wr_byte : SSSB_RESET; // [R8]
  assign clr_mon = (wr_done & hit_mon) ? wr_byte : SSSB_RESET; // [R8]
  // clear only what the read returned; an event caught while fetching stays pending
  assign clr_stat = (rd_done & hit_stat) ? wb_dat_o[7:0] : SSSB_RESET;

  sssb_sticky_reg #(
    .W(SSSB_DW)
  ) u_step_low (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .set_i(set_low),
    .clr_i(clr_low),
    .keep_i(SSSB_STEP_LOW_MASK),
    .flags_o(step_low),
    .event_o(ev_low)
  );

  sssb_sticky_reg #(
    .W(SSSB_DW)
  ) u_step_high (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .set_i(set_high),
    .clr_i(clr_high),
    .keep_i(SSSB_STEP_HIGH_MASK),
    .flags_o(step_high),
    .event_o(ev_high)
  );

  sssb_sticky_reg #(
    .W(SSSB_DW)
  ) u_mon (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .set_i(set_mon),
    .clr_i(clr_mon),
    .keep_i(mon_keep),
    .flags_o(mon),
    .event_o(ev_mon)
  );

  always_comb begin
    set_stat = SSSB_RESET;
    set_stat[SSSB_IRQ_STEP_LOW_BIT] = ev_low;
    set_stat[SSSB_IRQ_STEP_HIGH_BIT] = ev_high;
    set_stat[SSSB_IRQ_MON_BIT] = ev_mon;
  end

  // interrupt status, cleared by a read, set wins
  sssb_sticky_reg #(
    .W(SSSB_DW)
  ) u_irq_stat (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .set_i(set_stat),
    .clr_i(clr_stat),
    .keep_i(SSSB_IRQ_MASK_BITS),
    .flags_o(irq_stat),
    .event_o()
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= SSSB_RESET;
    end else if (ce_i && wr_done && hit_ctrl) begin
      ctrl <= wr_byte & SSSB_CTRL_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= SSSB_RESET;
    end else if (ce_i && wr_done && hit_mask) begin
      irq_mask <= wr_byte & SSSB_IRQ_MASK_BITS;
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

  // read mux; unmapped reads return zero
  always_comb begin
    next_rd = SSSB_RESET;
    if (hit_low) begin
      next_rd = step_low;
    end else if (hit_high) begin
      next_rd = step_high;
    end else if (hit_mon) begin
      next_rd = mon;
    end else if (hit_ctrl) begin
      next_rd = ctrl;
    end else if (hit_stat) begin
      next_rd = irq_stat;
    end else if (hit_mask) begin
      next_rd = irq_mask;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (cap) begin
      wb_dat_o <= {24'h000000, next_rd};
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // step registers
  s1_step_latch_a: assert property (ce_i && s1_divider_d_step_done_i |=> step_low[SSSB_S1_D_BIT]) // [R1]
    else $error("synth one divider D step not latched");
  s1_c_latch_a: assert property (ce_i && s1_divider_c_step_done_i |=> step_low[SSSB_S1_D_BIT - 1]) // [R1]
    else $error("synth one divider C step not latched");
  s1_b_latch_a: assert property (ce_i && s1_divider_b_step_done_i |=> step_low[SSSB_S1_A_BIT + 1]) // [R1]
    else $error("synth one divider B step not latched");
  s1_a_latch_a: assert property (ce_i && s1_divider_a_step_done_i |=> step_low[SSSB_S1_A_BIT]) // [R1]
    else $error("synth one divider A step not latched");
  s1_step_hold_a: assert property (step_low[SSSB_S1_A_BIT] && !clr_low[SSSB_S1_A_BIT] // [R1]
    |=> step_low[SSSB_S1_A_BIT])
    else $error("synth one divider A flag lost");
  s0_step_latch_a: assert property (ce_i && s0_divider_b_step_done_i |=> step_low[SSSB_S0_B_BIT]) // [R2]
    else $error("synth zero divider B step not latched");
  s0_a_latch_a: assert property (ce_i && s0_divider_a_step_done_i |=> step_low[SSSB_S0_A_BIT]) // [R2]
    else $error("synth zero divider A step not latched");
  low_reserved_a: assert property ((step_low & ~SSSB_STEP_LOW_MASK) == SSSB_RESET) // [R2]
    else $error("reserved bits of low step register set");
  s3_step_latch_a: assert property (ce_i && s3_divider_b_step_done_i |=> step_high[SSSB_S3_B_BIT]) // [R3]
    else $error("synth three divider B step not latched");
  s3_a_latch_a: assert property (ce_i && s3_divider_a_step_done_i |=> step_high[SSSB_S3_A_BIT]) // [R3]
    else $error("synth three divider A step not latched");
  high_reserved_a: assert property ((step_high & ~SSSB_STEP_HIGH_MASK) == SSSB_RESET) // [R3]
    else $error("reserved bits of high step register set");
  s2_step_latch_a: assert property (ce_i && s2_divider_c_step_done_i // [R4]
    |=> step_high[SSSB_S2_C_BIT])
    else $error("synth two divider C step not latched");
  s2_step_d_a: assert property (ce_i && s2_divider_d_step_done_i |=> step_high[SSSB_S2_D_BIT]) // [R4]
    else $error("synth two divider D step not latched");
  s2_b_latch_a: assert property (ce_i && s2_divider_b_step_done_i |=> step_high[SSSB_S2_A_BIT + 1]) // [R4]
    else $error("synth two divider B step not latched");
  s2_a_latch_a: assert property (ce_i && s2_divider_a_step_done_i |=> step_high[SSSB_S2_A_BIT]) // [R4]
    else $error("synth two divider A step not latched");

  // monitor register
  align_latch_a: assert property (ce_i && s0_align_a_done_i |=> mon[SSSB_MON_ALIGN_A_BIT]) // [R5]
    else $error("divider A alignment not latched");
  align_b_latch_a: assert property (ce_i && s0_align_b_done_i |=> mon[SSSB_MON_ALIGN_B_BIT]) // [R5]
    else $error("divider B alignment not latched");
  lol_latch_a: assert property (ce_i && synth_unlocked_flag_i |=> mon[SSSB_MON_LOL_BIT]) // [R6]
    else $error("synth_unlocked_flag not latched");
  lol_hold_a: assert property (mon[SSSB_MON_LOL_BIT] && !clr_mon[SSSB_MON_LOL_BIT] // [R6]
    |=> mon[SSSB_MON_LOL_BIT])
    else $error("synth_unlocked_flag flag dropped without acknowledge");
  alt_align_a: assert property (ce_i && ctrl_alt && s0_align_d_done_i |=> mon[SSSB_MON_ALIGN_D_BIT]) // [R7]
    else $error("divider D alignment not latched in alternate layout");
  align_c_latch_a: assert property (ce_i && ctrl_alt && s0_align_c_done_i |=> mon[SSSB_MON_ALIGN_C_BIT]) // [R7]
    else $error("divider C alignment not latched in alternate layout");
  std_align_c_a: assert property (ce_i && !ctrl_alt && !mon[SSSB_MON_ALIGN_C_BIT] // [R7]
    |=> !mon[SSSB_MON_ALIGN_C_BIT])
    else $error("divider C alignment latched in standard layout");
  mon_reserved_a: assert property ((mon & ~SSSB_MON_ALT_MASK) == SSSB_RESET) // [R7]
    else $error("reserved bits of monitor register set");

  // acknowledge and hold
  set_wins_a: assert property (ce_i && s0_divider_a_step_done_i && clr_low[SSSB_S0_A_BIT] // [R8]
    |=> step_low[SSSB_S0_A_BIT])
    else $error("event lost against acknowledge");
  ack_only_a: assert property ($fell(step_high[SSSB_S2_A_BIT]) |-> $past(clr_high[SSSB_S2_A_BIT])) // [R8]
    else $error("flag cleared without write of one");
  ack_clears_a: assert property (ce_i && clr_mon[SSSB_MON_ALIGN_A_BIT] && !s0_align_a_done_i // [R8]
    |=> !mon[SSSB_MON_ALIGN_A_BIT])
    else $error("write of one did not acknowledge flag");
  low_hold_a: assert property (!(wr_done && hit_low) // [R8]
    |=> (step_low & $past(step_low)) == $past(step_low))
    else $error("low step flag dropped without acknowledge");
  high_hold_a: assert property (!(wr_done && hit_high) // [R8]
    |=> (step_high & $past(step_high)) == $past(step_high))
    else $error("high step flag dropped without acknowledge");
  mon_hold_a: assert property (!(wr_done && hit_mon) // [R8]
    |=> (mon & $past(mon) & SSSB_MON_MASK) == ($past(mon) & SSSB_MON_MASK))
    else $error("monitor flag dropped without acknowledge");

  // interrupt status and control
  stat_rd_clear_a: assert property (rd_done && hit_stat && set_stat == SSSB_RESET
    |=> (irq_stat & $past(wb_dat_o[7:0])) == SSSB_RESET)
    else $error("status read did not clear reported bits");
  stat_no_loss_a: assert property (rd_done && hit_stat
    |=> ((irq_stat | $past(wb_dat_o[7:0])) & $past(irq_stat)) == $past(irq_stat))
    else $error("status event lost by a read");
  stat_hold_a: assert property (!(rd_done && hit_stat)
    |=> (irq_stat & $past(irq_stat)) == $past(irq_stat))
    else $error("status bit dropped without a read");
  ctrl_write_a: assert property (wr_done && hit_ctrl |=> ctrl == ($past(wr_byte) & SSSB_CTRL_MASK))
    else $error("control write not taken");
  mask_write_a: assert property (wr_done && hit_mask |=> irq_mask == ($past(wr_byte) & SSSB_IRQ_MASK_BITS))
    else $error("mask write not taken");
  irq_level_a: assert property (ce_i && ev_low && irq_mask[SSSB_IRQ_STEP_LOW_BIT] && !(wr_done && hit_mask)
    |=> irq_o)
    else $error("unmasked event did not raise interrupt");

  // bus and clock enable
  bus_ack_a: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o || !ce_i)
    else $error("bus ack not a single pulse after request");
  unmapped_zero_a: assert property (cap && !(hit_low || hit_high || hit_mon || hit_ctrl || hit_stat || hit_mask)
    |=> wb_dat_o == 32'h00000000)
    else $error("unmapped read returned data");
  ce_freeze_a: assert property (!ce_i |=> $stable(step_low) && $stable(step_high) && $stable(mon)
    && $stable(irq_stat) && $stable(ctrl) && $stable(irq_mask)
    && $stable(wb_ack_o) && $stable(wb_dat_o))
    else $error("state changed while clock enable low");

  set_clear_c: cover property (ce_i && s0_divider_a_step_done_i && clr_low[SSSB_S0_A_BIT]);
  irq_raise_c: cover property (!irq_o ##1 irq_o);
  alt_align_c: cover property (ctrl_alt && $rose(mon[SSSB_MON_ALIGN_D_BIT]));
  stat_read_c: cover property (rd_done && hit_stat && irq_stat != SSSB_RESET);
  ce_freeze_c: cover property (!ce_i && s0_divider_b_step_done_i);

endmodule : sssb_bank

// [tb/sssb_bank_tb_top.sv]
`timescale 1ns/1ps
module sssb_bank_tb_top;
  import sssb_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic [16:0] ev = 17'h00000;
  logic [16:0] hit = 17'h00000;
  logic [7:0] m;
  int miscompares = 0;
  int compares = 0;
  // bit position of each event input within its register
  int ev_bit [17] = '{0, 1, 4, 5, 6, 7, 0, 1, 2, 3, 4, 5, 4, 5, 2, 6, 7};
  // every mapped place plus one unmapped place
  logic [9:0] rst_idx [7] = '{SSSB_IDX_STEP_LOW, SSSB_IDX_STEP_HIGH, SSSB_IDX_MON, SSSB_IDX_CTRL,
                              SSSB_IDX_IRQ_STAT, SSSB_IDX_IRQ_MASK, 10'h1B7};

  always #12.5 clk_i = ~clk_i;

  sssb_bank #(.ADR_W(12)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .s0_divider_a_step_done_i(ev[0]), .s0_divider_b_step_done_i(ev[1]),
    .s1_divider_a_step_done_i(ev[2]), .s1_divider_b_step_done_i(ev[3]),
    .s1_divider_c_step_done_i(ev[4]), .s1_divider_d_step_done_i(ev[5]),
    .s2_divider_a_step_done_i(ev[6]), .s2_divider_b_step_done_i(ev[7]),
    .s2_divider_c_step_done_i(ev[8]), .s2_divider_d_step_done_i(ev[9]),
    .s3_divider_a_step_done_i(ev[10]), .s3_divider_b_step_done_i(ev[11]),
    .s0_align_a_done_i(ev[12]), .s0_align_b_done_i(ev[13]), .synth_unlocked_flag_i(ev[14]),
    .s0_align_c_done_i(ev[15]), .s0_align_d_done_i(ev[16]), .irq_o(irq)
  );

  function automatic logic [9:0] ev_reg(input int i);
    if (i < 6) return SSSB_IDX_STEP_LOW;
    if (i < 12) return SSSB_IDX_STEP_HIGH;
    return SSSB_IDX_MON;
  endfunction : ev_reg

  task automatic test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; hit pulses events in the cycle the write commits
  task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d, input logic [3:0] s,
                     output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
      ev <= (n == 1) ? hit : 17'h00000;
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, 4'h1, r);
  endtask : wr

  task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, idx, 8'h00, 4'hF, r);
    chk(r, {24'h000000, e});
  endtask : rdc

  task automatic pulse(input logic [16:0] p);
    ev <= p;
    @(posedge clk_i);
    ev <= 17'h00000;
  endtask : pulse

  task automatic irqc(input logic e);
    @(negedge clk_i);
    chk({31'h00000000, irq}, {31'h00000000, e});
    @(posedge clk_i);
  endtask : irqc

  initial begin
    logic [31:0] r;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // reset values, unmapped place included
    foreach (rst_idx[i]) begin
      rdc(rst_idx[i], SSSB_RESET);
    end
    irqc(1'b0);
    // every standard-layout event alone (not alignment C and D): set, hold, ignore other bits, clear
    for (int i = 0; i < 15; i++) begin
      m = 8'h01 << ev_bit[i];
      pulse(17'h00001 << i);
      rdc(ev_reg(i), m);
      wr(ev_reg(i), ~m);
      rdc(ev_reg(i), m);
      wr(ev_reg(i), m);
      rdc(ev_reg(i), 8'h00);
    end
    // all events at once, reserved bits stay zero, standard layout ignores C and D
    pulse(17'h1FFFF);
    rdc(SSSB_IDX_STEP_LOW, 8'hF3);
    rdc(SSSB_IDX_STEP_HIGH, 8'h3F);
    rdc(SSSB_IDX_MON, 8'h34);
    bus(1'b1, SSSB_IDX_STEP_LOW, 8'hFF, 4'h0, r);
    rdc(SSSB_IDX_STEP_LOW, 8'hF3);
    wr(SSSB_IDX_STEP_LOW, 8'hFF);
    wr(SSSB_IDX_STEP_HIGH, 8'hFF);
    wr(SSSB_IDX_MON, 8'hFF);
    rdc(SSSB_IDX_STEP_LOW, 8'h00);
    rdc(SSSB_IDX_STEP_HIGH, 8'h00);
    rdc(SSSB_IDX_MON, 8'h00);
    // alternate layout
    wr(SSSB_IDX_CTRL, 8'hFF);
    rdc(SSSB_IDX_CTRL, 8'h01);
    pulse(17'h1C000);
    rdc(SSSB_IDX_MON, 8'hC4);
    wr(SSSB_IDX_MON, 8'hC0);
    rdc(SSSB_IDX_MON, 8'h04);
    wr(SSSB_IDX_MON, 8'h04);
    wr(SSSB_IDX_CTRL, 8'h00);
    // event in the same cycle as the acknowledge
    pulse(17'h00001);
    hit = 17'h00001;
    wr(SSSB_IDX_STEP_LOW, 8'h01);
    hit = 17'h00000;
    rdc(SSSB_IDX_STEP_LOW, 8'h01);
    wr(SSSB_IDX_STEP_LOW, 8'h01);
    // frozen while the clock enable is low
    ce <= 1'b0;
    pulse(17'h00002);
    ce <= 1'b1;
    rdc(SSSB_IDX_STEP_LOW, 8'h00);
    // interrupt status, mask and clear on read
    rdc(SSSB_IDX_IRQ_STAT, 8'h07);
    rdc(SSSB_IDX_IRQ_STAT, 8'h00);
    wr(SSSB_IDX_IRQ_MASK, 8'hFF);
    rdc(SSSB_IDX_IRQ_MASK, 8'h07);
    pulse(17'h00040);
    irqc(1'b1);
    rdc(SSSB_IDX_IRQ_STAT, 8'h02);
    irqc(1'b0);
    wr(SSSB_IDX_IRQ_MASK, 8'h01);
    pulse(17'h01000);
    irqc(1'b0);
    rdc(SSSB_IDX_IRQ_STAT, 8'h04);
    wr(10'h1B7, 8'hFF);
    rdc(10'h1B7, 8'h00);
    rdc(SSSB_IDX_STEP_HIGH, 8'h01);
    // reset in mid-run clears flags and mask left set above
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(SSSB_IDX_STEP_HIGH, SSSB_RESET);
    rdc(SSSB_IDX_MON, SSSB_RESET);
    rdc(SSSB_IDX_IRQ_MASK, SSSB_RESET);
    irqc(1'b0);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    test_done();
  end
endmodule : sssb_bank_tb_top
